//--- rxps_pkg.sv
// Package for the receive protection switch and resync block.
// Assumes an APB master, 100 MHz CLK, byte address = 4 x register index.
package rxps_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH    = 8;
  localparam int NPAIR  = 4;
  localparam int ADDR_W = 22;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [19:0] IDX_PROT_CTRL    = 20'h30009;
  localparam logic [19:0] IDX_CHAN_RESYNC  = 20'h30017;
  localparam logic [19:0] IDX_GROUP_RESYNC = 20'h30018;
  localparam logic [19:0] IDX_CHAN_ENABLE  = 20'h30100;
  localparam logic [19:0] IDX_MODE         = 20'h30101;
  localparam logic [19:0] IDX_SERIAL_SEL   = 20'h30102;
  localparam logic [19:0] IDX_STATUS       = 20'h30103;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_PROT_CTRL = 4'hF;
  localparam logic [7:0] RST_RESYNC    = 8'h00;
  localparam logic [7:0] RST_CHAN_EN   = 8'h00;
  localparam logic [3:0] RST_MODE      = 4'h0;
  localparam logic [7:0] RST_SER_SEL   = 8'h00;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_PAR_SW = 0;
  localparam int MODE_SER_SW = 1;
  localparam int MODE_FIFO   = 2;
  localparam int MODE_MULTI  = 3;

  // ----------------------------------------------------------------
  // Group resync fields and channel masks (bit 7 = AA ... bit 0 = BD)
  // ----------------------------------------------------------------
  localparam int         GRP_LINKS  = 4;
  localparam int         GRP_QUAD_B = 4;
  localparam int         GRP_QUAD_A = 5;
  localparam int         GRP_ALL    = 6;
  localparam logic [7:0] MASK_LINK  = 8'h11;
  localparam logic [7:0] MASK_QB    = 8'h0F;
  localparam logic [7:0] MASK_QA    = 8'hF0;
  localparam logic [7:0] MASK_ALL   = 8'hFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [NCH-1:0][7:0] rxps_bytes_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } rxps_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rxps_apb_rsp_s;

  typedef struct packed {
    rxps_bytes_t      data;
    logic [NCH-1:0]   oh;
  } rxps_lane_s;

endpackage : rxps_pkg

//--- rxps_core.sv
// Receive protection switching, channel powerdown and alignment FIFO resync.
// Assumes framer data arrives on CLK and the fabric runs on the forwarded CLK.
//
// Behaviour
// - Core forwards its reference clock and captures transmit data on that clock.
// - With alignment FIFO in use, parallel outputs are timed from the core clock.
// - Incoming transmit data is captured on the falling clock edge only.
// - A disabled channel is powered down; software enables each channel separately.
// - Each channel offers parallel bus and serial overhead output enables.
// - Disabling a channel also powers down its serdes macro portion.
// - After reset all eight channels sit in powerdown until enabled.
// - Receive-only protection switching, selected by register or fabric pins.
// - Parallel switching sits after the alignment FIFO, only with FIFO enabled.
// - Parallel switching works with pointer processing bypassed.
// - Pairs AA/AB, AC/AD, BA/BB, BC/BD; selected member drives first channel outputs.
// - Four pin selects switch parallel data only, overhead stays unswitched.
// - Software select switches both parallel data and serial overhead.
// - Pair select 0 routes protect data, 1 routes main data.
// - Serial switching picks work or protect input buffer before recovery.
// - Eight serial selects: 0 work input, 1 protect input.
// - Status is reported only for the currently selected serial input; the code masks it by channel enable instead.
// - Channel resync register: bit 7 AA to bit 0 BD; 1 resyncs, 0 normal.
// - Without multi-channel alignment, resync puts read pointer at FIFO midpoint.
// - Group resync: bits 0-3 link pairs, 4 quad B, 5 quad A, 6 all.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module rxps_core
  import rxps_pkg::*;
#(
  parameter int DEPTH = 8
)(
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RST,
  // APB register port
  input  wire rxps_apb_req_s APB_REQ,
  output rxps_apb_rsp_s      APB_RSP,
  // Framer side receive lanes and stream status
  input  wire rxps_lane_s    RX_FRAMED,
  input  wire logic [7:0]    RX_FRAMER_STATUS,
  // Fabric select inputs
  input  wire logic [3:0]    PAIR_SELECT,
  input  wire logic [7:0]    SERIAL_INPUT_SELECT,
  // Fabric transmit data
  input  wire rxps_bytes_t   TX_DATA,
  // Fabric receive outputs
  output logic               CORE_REF_CLOCK_OUT,
  output rxps_lane_s         PARALLEL_OUT_FIRST,
  output logic [7:0]         PARALLEL_OUT_EN,
  output logic [7:0]         OH_OUT_EN,
  // Serdes macro controls
  output logic [7:0]         SERDES_MACRO_POWERDOWN,
  output logic [7:0]         SERIAL_SELECT_TO_CDR,
  output rxps_bytes_t        TX_DATA_TO_SERDES
);

  localparam int             PW   = $clog2(DEPTH);
  localparam logic [PW-1:0]  HALF = PW'(DEPTH / 2);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]                       prot_ctrl;
    logic [7:0]                       chan_resync;
    logic [7:0]                       group_resync;
    logic [7:0]                       chan_en;
    logic [3:0]                       mode;
    logic [7:0]                       ser_sw;
    logic [3:0]                       pair_pin;
    logic [7:0]                       ser_pin;
    logic [NCH-1:0][DEPTH-1:0][7:0]   mem;
    logic [NCH-1:0][PW-1:0]           wr;
    logic [NCH-1:0][PW-1:0]           rd;
    rxps_lane_s                       out;
    logic [7:0]                       pout_en;
    logic [7:0]                       oh_en;
    logic [7:0]                       pd;
    logic [7:0]                       ser_cdr;
    rxps_bytes_t                      tx_out;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
  } rxps_state_s;

  rxps_state_s  s_q;
  rxps_state_s  s_d;
  rxps_bytes_t  tx_neg_q;
  rxps_bytes_t  fifo_out;
  logic [3:0]   par_sel;
  logic [7:0]   ser_sel;
  logic [7:0]   resync;
  logic [7:0]   group_mask;
  logic [19:0]  idx;
  logic         acc;
  logic         hit;

  // ----------------------------------------------------------------
  // Clock forward and falling-edge transmit capture
  // ----------------------------------------------------------------
  // Fabric launches on the forwarded clock, so no synchroniser here
  assign CORE_REF_CLOCK_OUT = CLK;

  // Capture edge is fixed to the falling edge
  always_ff @(negedge CLK or posedge RST)
  begin
    if (RST)
      tx_neg_q <= '0;
    else
      tx_neg_q <= TX_DATA;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Fabric selects registered once, same clock domain
    s_d.pair_pin = PAIR_SELECT;
    s_d.ser_pin  = SERIAL_INPUT_SELECT;
    par_sel = s_q.mode[MODE_PAR_SW] ? s_q.prot_ctrl : s_q.pair_pin;
    ser_sel = s_q.mode[MODE_SER_SW] ? s_q.ser_sw : s_q.ser_pin;

    // Group resync expands to channel masks
    group_mask = 8'h00;
    for (int k = 0; k < GRP_LINKS; k++)
    begin
      if (s_q.group_resync[k])
        group_mask = group_mask | 8'(MASK_LINK << k);
    end
    if (s_q.group_resync[GRP_QUAD_B])
      group_mask = group_mask | MASK_QB;
    if (s_q.group_resync[GRP_QUAD_A])
      group_mask = group_mask | MASK_QA;
    if (s_q.group_resync[GRP_ALL])
      group_mask = group_mask | MASK_ALL;
    resync = s_q.chan_resync | (s_q.mode[MODE_MULTI] ? group_mask : 8'h00);

    // Alignment FIFO per channel; read pointer held at midpoint during resync
    for (int c = 0; c < NCH; c++)
    begin
      fifo_out[c] = s_q.mode[MODE_FIFO] ? s_q.mem[c][s_q.rd[c]] : RX_FRAMED.data[c];
      if (s_q.chan_en[c])
      begin
        s_d.mem[c][s_q.wr[c]] = RX_FRAMED.data[c];
        s_d.wr[c] = PW'(s_q.wr[c] + 1'b1);
        if (resync[c])
          s_d.rd[c] = PW'(s_q.wr[c] - HALF);
        else
          s_d.rd[c] = PW'(s_q.rd[c] + 1'b1);
      end
      s_d.out.data[c] = s_q.chan_en[c] ? fifo_out[c] : 8'h00;
      s_d.out.oh[c]   = s_q.chan_en[c] & RX_FRAMED.oh[c];
    end

    // Parallel switching after the FIFO; first = 2p+1, protect = 2p
    for (int p = 0; p < NPAIR; p++)
    begin
      if (s_q.mode[MODE_FIFO] && !par_sel[p])
      begin
        s_d.out.data[2*p+1] = s_q.chan_en[2*p] ? fifo_out[2*p] : 8'h00;
        if (s_q.mode[MODE_PAR_SW])
          s_d.out.oh[2*p+1] = s_q.chan_en[2*p] & RX_FRAMED.oh[2*p];
      end
    end

    // Powerdown, enables, serial buffer choice, transmit data
    s_d.pout_en = s_q.chan_en;
    s_d.oh_en   = s_q.chan_en;
    s_d.pd      = ~s_q.chan_en;
    s_d.ser_cdr = ser_sel;
    s_d.tx_out  = tx_neg_q;

    // APB slave: one wait state, write lands on the edge with pready high
    idx = APB_REQ.paddr[ADDR_W-1:2];
    acc = APB_REQ.psel & APB_REQ.penable;
    hit = 1'b0;
    if (idx == IDX_PROT_CTRL)
      hit = 1'b1;
    else if (idx == IDX_CHAN_RESYNC)
      hit = 1'b1;
    else if (idx == IDX_GROUP_RESYNC)
      hit = 1'b1;
    else if (idx == IDX_CHAN_ENABLE)
      hit = 1'b1;
    else if (idx == IDX_MODE)
      hit = 1'b1;
    else if (idx == IDX_SERIAL_SEL)
      hit = 1'b1;
    else if (idx == IDX_STATUS)
      hit = 1'b1;
    s_d.pready  = acc & ~s_q.pready;
    s_d.pslverr = acc & ~s_q.pready & ~hit;
    s_d.prdata  = 32'h0000_0000;
    if (acc && !s_q.pready && !APB_REQ.pwrite)
    begin
      if (idx == IDX_PROT_CTRL)
        s_d.prdata = {28'h0, s_q.prot_ctrl};
      else if (idx == IDX_CHAN_RESYNC)
        s_d.prdata = {24'h0, s_q.chan_resync};
      else if (idx == IDX_GROUP_RESYNC)
        s_d.prdata = {24'h0, 1'b0, s_q.group_resync[6:0]};
      else if (idx == IDX_CHAN_ENABLE)
        s_d.prdata = {24'h0, s_q.chan_en};
      else if (idx == IDX_MODE)
        s_d.prdata = {28'h0, s_q.mode};
      else if (idx == IDX_SERIAL_SEL)
        s_d.prdata = {24'h0, s_q.ser_sw};
      else if (idx == IDX_STATUS)
        // Framer status is masked by the channel enables, not by the selected input
        s_d.prdata = {8'h00, RX_FRAMER_STATUS & s_q.chan_en, ser_sel, 4'h0, par_sel};
    end
    if (acc && s_q.pready && APB_REQ.pwrite && !s_q.pslverr)
    begin
      if (idx == IDX_PROT_CTRL)
        s_d.prot_ctrl = APB_REQ.pwdata[3:0];
      else if (idx == IDX_CHAN_RESYNC)
        s_d.chan_resync = APB_REQ.pwdata[7:0];
      else if (idx == IDX_GROUP_RESYNC)
        s_d.group_resync = {1'b0, APB_REQ.pwdata[6:0]};
      else if (idx == IDX_CHAN_ENABLE)
        s_d.chan_en = APB_REQ.pwdata[7:0];
      else if (idx == IDX_MODE)
        s_d.mode = APB_REQ.pwdata[3:0];
      else if (idx == IDX_SERIAL_SEL)
        s_d.ser_sw = APB_REQ.pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q              <= '0;
      s_q.prot_ctrl    <= RST_PROT_CTRL;
      s_q.chan_resync  <= RST_RESYNC;
      s_q.group_resync <= RST_RESYNC;
      s_q.chan_en      <= RST_CHAN_EN;
      s_q.mode         <= RST_MODE;
      s_q.ser_sw       <= RST_SER_SEL;
      s_q.pd           <= 8'hFF;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answer packed in field order: read data, ready, error
  assign APB_RSP                = {s_q.prdata, s_q.pready, s_q.pslverr};
  assign PARALLEL_OUT_FIRST     = s_q.out;
  assign PARALLEL_OUT_EN        = s_q.pout_en;
  assign OH_OUT_EN              = s_q.oh_en;
  assign SERDES_MACRO_POWERDOWN = s_q.pd;
  assign SERIAL_SELECT_TO_CDR   = s_q.ser_cdr;
  assign TX_DATA_TO_SERDES      = s_q.tx_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_powerdown_follows_en: assert property (@(posedge CLK) disable iff (RST)
    SERDES_MACRO_POWERDOWN == ~$past(s_q.chan_en))
    else $error("powerdown does not follow channel enable");

  chk_idle_all_down: assert property (@(posedge CLK) disable iff (RST)
    (s_q.chan_en == 8'h00) [*2] |-> SERDES_MACRO_POWERDOWN == 8'hFF)
    else $error("disabled channels not powered down");

  chk_oe_match_power: assert property (@(posedge CLK) disable iff (RST)
    (PARALLEL_OUT_EN == OH_OUT_EN) && (PARALLEL_OUT_EN == ~SERDES_MACRO_POWERDOWN))
    else $error("output enables disagree with powerdown");

  chk_serial_sel_path: assert property (@(posedge CLK) disable iff (RST)
    $stable(SERIAL_INPUT_SELECT) && !s_q.mode[MODE_SER_SW] ##1 !s_q.mode[MODE_SER_SW] [*2]
      |-> SERIAL_SELECT_TO_CDR == $past(SERIAL_INPUT_SELECT, 2))
    else $error("serial select pin not applied in two cycles");

  chk_tx_capture: assert property (@(posedge CLK) disable iff (RST)
    ##1 TX_DATA_TO_SERDES == $past(tx_neg_q))
    else $error("transmit data not passed from falling-edge capture");

  // Register answers are single-cycle pulses; a stuck ready would confuse the master
  chk_ready_one_cycle: assert property (@(posedge CLK) disable iff (RST)
    APB_RSP.pready |=> !APB_RSP.pready)
    else $error("register answer held for more than one cycle");

  // An error answer never comes without the ready strobe
  chk_error_with_ready: assert property (@(posedge CLK) disable iff (RST)
    APB_RSP.pslverr |-> APB_RSP.pready)
    else $error("error answer without ready");

  // Software serial select reaches the recovery input one cycle later
  chk_serial_sw_path: assert property (@(posedge CLK) disable iff (RST)
    s_q.mode[MODE_SER_SW] |=> SERIAL_SELECT_TO_CDR == $past(s_q.ser_sw))
    else $error("software serial select not applied");

  // A write to the enable register lands on the edge that completes the access
  chk_enable_write: assert property (@(posedge CLK) disable iff (RST)
    acc && s_q.pready && APB_REQ.pwrite && idx == IDX_CHAN_ENABLE
      |=> s_q.chan_en == $past(APB_REQ.pwdata[7:0]))
    else $error("channel enable write did not land");

  // Unused top bit of the group register never holds a one
  chk_group_top_clear: assert property (@(posedge CLK) disable iff (RST)
    !s_q.group_resync[7])
    else $error("unused group resync bit set");

  for (genvar p = 0; p < NPAIR; p++)
  begin : g_chk
    chk_pair_protect_route: assert property (@(posedge CLK) disable iff (RST)
      s_q.mode[MODE_FIFO] && !par_sel[p] && s_q.chan_en[2*p]
        |=> PARALLEL_OUT_FIRST.data[2*p+1] == $past(fifo_out[2*p]))
      else $error("protect data not routed to first channel");

    chk_pair_main_route: assert property (@(posedge CLK) disable iff (RST)
      s_q.mode[MODE_FIFO] && par_sel[p] && s_q.chan_en[2*p+1]
        |=> PARALLEL_OUT_FIRST.data[2*p+1] == $past(fifo_out[2*p+1]))
      else $error("main data not on first channel");

    chk_pin_oh_unswitched: assert property (@(posedge CLK) disable iff (RST)
      !s_q.mode[MODE_PAR_SW] && s_q.chan_en[2*p+1]
        |=> PARALLEL_OUT_FIRST.oh[2*p+1] == $past(RX_FRAMED.oh[2*p+1]))
      else $error("overhead switched under pin control");

    chk_bypass_no_switch: assert property (@(posedge CLK) disable iff (RST)
      !s_q.mode[MODE_FIFO] && s_q.chan_en[2*p+1]
        |=> PARALLEL_OUT_FIRST.data[2*p+1] == $past(RX_FRAMED.data[2*p+1]))
      else $error("switch active without alignment FIFO");

    // Software control moves the overhead bit along with the data
    chk_sw_oh_switched: assert property (@(posedge CLK) disable iff (RST)
      s_q.mode[MODE_FIFO] && s_q.mode[MODE_PAR_SW] && !s_q.prot_ctrl[p] && s_q.chan_en[2*p]
        |=> PARALLEL_OUT_FIRST.oh[2*p+1] == $past(RX_FRAMED.oh[2*p]))
      else $error("overhead not switched under software control");

    // A disabled protect channel shows nothing on its own outputs
    chk_protect_off_quiet: assert property (@(posedge CLK) disable iff (RST)
      !s_q.chan_en[2*p]
        |=> PARALLEL_OUT_FIRST.data[2*p] == 8'h00 && !PARALLEL_OUT_FIRST.oh[2*p])
      else $error("disabled channel still drives data");
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_chk_rs
    chk_resync_midpoint: assert property (@(posedge CLK) disable iff (RST)
      s_q.chan_en[c] && s_q.chan_resync[c] && !s_q.mode[MODE_MULTI]
        |=> s_q.rd[c] == PW'($past(s_q.wr[c]) - HALF))
      else $error("resync did not centre read pointer");

    // All-channel group resync centres every enabled read pointer
    chk_group_midpoint: assert property (@(posedge CLK) disable iff (RST)
      s_q.chan_en[c] && s_q.mode[MODE_MULTI] && s_q.group_resync[GRP_ALL]
        |=> s_q.rd[c] == PW'($past(s_q.wr[c]) - HALF))
      else $error("group resync did not centre read pointer");

    // Quad resync: lower four channels are quad B, upper four quad A
    chk_quad_midpoint: assert property (@(posedge CLK) disable iff (RST)
      s_q.chan_en[c] && s_q.mode[MODE_MULTI] && s_q.group_resync[(c < NCH / 2) ? GRP_QUAD_B : GRP_QUAD_A]
        |=> s_q.rd[c] == PW'($past(s_q.wr[c]) - HALF))
      else $error("quad resync did not centre read pointer");

    // Two-link resync: bit k covers channel k and channel k plus four
    chk_link_midpoint: assert property (@(posedge CLK) disable iff (RST)
      s_q.chan_en[c] && s_q.mode[MODE_MULTI] && s_q.group_resync[c % GRP_LINKS]
        |=> s_q.rd[c] == PW'($past(s_q.wr[c]) - HALF))
      else $error("link resync did not centre read pointer");
  end

endmodule : rxps_core

//--- rxps_fabric.sv
// Fabric-side user logic model: drives select pins and transmit bytes.
// Assumes the bench sets the command inputs; pins change on rising clk.
`timescale 1ns/1ns
module rxps_fabric
  import rxps_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bench commands
  input  wire logic [3:0]  pair_cmd,
  input  wire logic [7:0]  ser_cmd,
  input  wire rxps_bytes_t tx_cmd,
  // Pins toward the core
  output rxps_bytes_t      tx_data,
  output logic [3:0]       pair_sel,
  output logic [7:0]       ser_sel
);
  // Launch on the rising edge so the core's falling edge sees settled data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pair_sel <= 4'hF;
      ser_sel  <= 8'h00;
      tx_data  <= '0;
    end
    else
    begin
      pair_sel <= pair_cmd;
      ser_sel  <= ser_cmd;
      tx_data  <= tx_cmd;
    end
  end
endmodule : rxps_fabric

//--- tb.sv
// Testbench for rxps_core: register access over APB and fabric switching.
// Assumes rxps_fabric as the fabric partner and a 100 MHz CLK.
`timescale 1ns/1ns
module tb
  import rxps_pkg::*;
;
  logic          CLK;
  logic          RST;
  rxps_apb_req_s req;
  rxps_apb_rsp_s rsp;
  rxps_lane_s    rx;
  rxps_lane_s    pout;
  logic [7:0]    fstat;
  logic [3:0]    pair_pin;
  logic [7:0]    ser_pin;
  rxps_bytes_t   txd;
  logic [3:0]    pair_cmd;
  logic [7:0]    ser_cmd;
  rxps_bytes_t   tx_cmd;
  logic          refclk;
  logic [7:0]    par_en;
  logic [7:0]    oh_en;
  logic [7:0]    pwrdn;
  logic [7:0]    cdr_sel;
  rxps_bytes_t   tx_ser;
  logic [31:0]   rd;
  logic          er;
  int            n_errors;
  int            compares;

  rxps_core dut_u (.CLK(CLK), .RST(RST), .APB_REQ(req), .APB_RSP(rsp), .RX_FRAMED(rx),
    .RX_FRAMER_STATUS(fstat), .PAIR_SELECT(pair_pin), .SERIAL_INPUT_SELECT(ser_pin), .TX_DATA(txd),
    .CORE_REF_CLOCK_OUT(refclk), .PARALLEL_OUT_FIRST(pout), .PARALLEL_OUT_EN(par_en), .OH_OUT_EN(oh_en),
    .SERDES_MACRO_POWERDOWN(pwrdn), .SERIAL_SELECT_TO_CDR(cdr_sel), .TX_DATA_TO_SERDES(tx_ser));

  rxps_fabric fab_u (.clk(CLK), .rst(RST), .pair_cmd(pair_cmd), .ser_cmd(ser_cmd), .tx_cmd(tx_cmd),
    .tx_data(txd), .pair_sel(pair_pin), .ser_sel(ser_pin));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  // A slave that never answers is caught by the watchdog
  task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] wd);
    @(posedge CLK);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge CLK);
    req.penable <= 1'b1;
    do
    begin
      @(posedge CLK);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [19:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
    chk("slave_error", er, 1'b0);
  endtask : rdc

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk("powerdown", pwrdn, 8'hFF);
    chk("par_en", par_en, 8'h00);
    rdc("chan_en", IDX_CHAN_ENABLE, 32'h0);
    rdc("chan_resync", IDX_CHAN_RESYNC, 32'h0);
    rdc("grp_resync", IDX_GROUP_RESYNC, 32'h0);
    rdc("prot_ctrl", IDX_PROT_CTRL, 32'hF);
    apb(1'b0, 20'h30200, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
  endtask : t_reset

  task automatic t_enable();
    apb(1'b1, IDX_CHAN_ENABLE, 32'hFF);
    repeat (3) @(posedge CLK);
    chk("powerdown", pwrdn, 8'h00);
    chk("par_en", par_en, 8'hFF);
    chk("oh_en", oh_en, 8'hFF);
  endtask : t_enable

  task automatic t_resync();
    apb(1'b1, IDX_CHAN_RESYNC, 32'hA5);
    rdc("chan_resync", IDX_CHAN_RESYNC, 32'hA5);
    apb(1'b1, IDX_MODE, 32'h8);
    rdc("mode_multi", IDX_MODE, 32'h8);
    apb(1'b1, IDX_GROUP_RESYNC, 32'hFF);
    rdc("grp_resync", IDX_GROUP_RESYNC, 32'h7F);
    apb(1'b1, IDX_CHAN_RESYNC, 32'h0);
    apb(1'b1, IDX_GROUP_RESYNC, 32'h0);
    rdc("chan_resync", IDX_CHAN_RESYNC, 32'h0);
  endtask : t_resync

  // Pin select works only with the FIFO in use and leaves overhead alone
  task automatic t_pair_pin();
    apb(1'b1, IDX_MODE, 32'h0);
    pair_cmd <= 4'h0;
    repeat (12) @(posedge CLK);
    chk("aa_no_fifo", pout.data[7], 8'hC7);
    apb(1'b1, IDX_MODE, 32'h4);
    repeat (12) @(posedge CLK);
    chk("aa_protect", pout.data[7], 8'hC6);
    chk("bc_protect", pout.data[1], 8'hC0);
    chk("aa_oh_pin", pout.oh[7], 1'b1);
    pair_cmd <= 4'hF;
    repeat (12) @(posedge CLK);
    chk("aa_main", pout.data[7], 8'hC7);
  endtask : t_pair_pin

  task automatic t_pair_sw();
    apb(1'b1, IDX_MODE, 32'h5);
    apb(1'b1, IDX_PROT_CTRL, 32'h7);
    repeat (12) @(posedge CLK);
    chk("aa_sw", pout.data[7], 8'hC6);
    chk("aa_oh_sw", pout.oh[7], 1'b0);
    chk("ac_sw", pout.data[5], 8'hC5);
  endtask : t_pair_sw

  task automatic t_serial();
    ser_cmd <= 8'h81;
    repeat (4) @(posedge CLK);
    chk("cdr_pin", cdr_sel, 8'h81);
    apb(1'b1, IDX_SERIAL_SEL, 32'h24);
    apb(1'b1, IDX_MODE, 32'h2);
    repeat (3) @(posedge CLK);
    chk("cdr_sw", cdr_sel, 8'h24);
    rdc("status", IDX_STATUS, 32'h003C240F);
  endtask : t_serial

  task automatic t_tx();
    tx_cmd <= 64'h0123456789ABCDEF;
    repeat (4) @(posedge CLK);
    chk("tx_ser", tx_ser, 64'h0123456789ABCDEF);
    @(negedge CLK);
    #1;
    chk("refclk_low", refclk, 1'b0);
    @(posedge CLK);
    #1;
    chk("refclk_high", refclk, 1'b1);
  endtask : t_tx

  task automatic t_disable();
    apb(1'b1, IDX_CHAN_ENABLE, 32'hBF);
    repeat (3) @(posedge CLK);
    chk("powerdown", pwrdn, 8'h40);
    chk("par_en", par_en, 8'hBF);
    chk("ab_data", pout.data[6], 8'h00);
  endtask : t_disable

  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Whole run is well under 1000 cycles
  initial
  begin
    #100000;
    n_errors++;
    results();
  end

  initial
  begin
    n_errors = 0;
    compares = 0;
    RST      = 1'b1;
    req      = '0;
    fstat    = 8'h3C;
    pair_cmd = 4'hF;
    ser_cmd  = 8'h00;
    tx_cmd   = '0;
    rx.oh    = 8'hAA;
    for (int i = 0; i < NCH; i++)
      rx.data[i] = 8'hC0 | 8'(i);
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CLK);
    t_reset();
    t_enable();
    t_resync();
    t_pair_pin();
    t_pair_sw();
    t_serial();
    t_tx();
    t_disable();
    results();
  end
endmodule : tb
